// ==== shared/uab_defs.svh ====
// register map, field positions, reset values and divider counts for the autobaud/wake/break block
`ifndef UAB_DEFS_SVH
`define UAB_DEFS_SVH
`define UAB_ADDR_CTRL 8'h00
`define UAB_ADDR_DIV 8'h04
`define UAB_ADDR_TXDATA 8'h08
`define UAB_ADDR_RXDATA 8'h0C
`define UAB_BIT_ABD_EN 0
`define UAB_BIT_WAKE_EN 1
`define UAB_BIT_SEND_BRK 2
`define UAB_BIT_TX_EN 3
`define UAB_BIT_WIDE 4
`define UAB_BIT_HIGH 5
`define UAB_BIT_SYNC 6
`define UAB_BIT_ABD_OVF 7
`define UAB_BIT_RX_IDLE 8
`define UAB_BIT_SHIFT_EMPTY 9
`define UAB_BIT_RX_FLAG 10
`define UAB_DIV_RESET 16'h0000
`define UAB_BASE_DIV_SLOW 6'd63
`define UAB_BASE_DIV_MID 6'd15
`define UAB_BASE_DIV_FAST 6'd3
`define UAB_ABD_SUBDIV 3'd7
`define UAB_ABD_START_COUNT 16'h0001
`define UAB_ABD_RISES 3'd4
`define UAB_BRK_ZERO_BITS 4'd13
`define UAB_BRK_LAST_BIT 4'd13
`endif

// ==== shared/uab_pkg.sv ====
// types shared by the autobaud/wake/break block
package uab_pkg;
	typedef enum logic [4:0] {
		AB_IDLE = 5'b00001,
		AB_BREAK = 5'b00010,
		AB_START = 5'b00100,
		AB_RISE1 = 5'b01000,
		AB_COUNT = 5'b10000
	} uab_ab_state_t;
	typedef enum logic [2:0] {
		WK_IDLE = 3'b001,
		WK_LOW = 3'b010,
		WK_HIGH = 3'b100
	} uab_wake_state_t;
	typedef struct packed {
		logic start;
		logic [7:0] data;
	} uab_tx_req_t;
	typedef struct packed {
		logic done;
		logic [7:0] data;
	} uab_rx_byte_t;
endpackage

// ==== core/uab_core.sv ====
// autobaud measurement, wake-on-break and break transmission with an APB register slave
// Function
// - setting autobaud enable starts calibration; normal receiver held idle meanwhile
// - time sync byte from first rising edge after start to fifth rising edge
// - at fifth rise store count in divisor pair, clear enable, set receive flag
// - reading receive data clears receive flag; software discards that byte
// - both divisor bytes form one 16-bit counter during calibration
// - calibration counter runs at clk/512, /128 or /32 by rate selects
// - calibration count starts at one; software subtracts one
// - overflow past 16 bits sets overflow flag; counting continues to fifth rise
// - overflow flag clears by software only once enable is clear
// - with wake and autobaud both enabled, measure the byte after the break
// - wake-on-break only in asynchronous mode
// - while wake enabled, normal receive disabled; watch for falling receive edge
// - wake event raises receive flag at once
// - rising edge ending the break clears wake enable; then idle
// - non-zero character: low time to first rise counts as wake event
// - break is start bit, twelve zero bits, then stop bit
// - transmit data write with send-break and transmit enable starts break
// - send-break clears after stop bit; preloaded byte then follows
// - shift empty status shows break activity like normal characters
`timescale 1ns/10ps
`include "uab_defs.svh"
module uab_core
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic receive_line,
	input wire uab_pkg::uab_rx_byte_t rx_byte_in,
	input wire logic rx_busy_in,
	input wire logic tx_shift_busy_in,
	input wire logic tx_line_normal,
	output logic tx_line,
	output logic rx_hold,
	output logic [15:0] divisor_pair,
	output uab_pkg::uab_tx_req_t tx_req
);
	import uab_pkg::*;

	logic autobaud_enable, wake_enable, send_break, transmit_enable;
	logic wide_divisor_select, high_rate_select, sync_mode;
	logic autobaud_overflow_flag, receive_flag;
	logic [7:0] receive_data_reg, hold_data;
	logic rx_s1, rx_s2, rx_s3, rx_lvl, rx_rise, rx_fall;
	logic [5:0] base_cnt, base_max;
	logic base_tick, abd_tick, bit_tick;
	logic [2:0] abd_sub, ab_rises;
	logic [15:0] bit_cnt, ab_count;
	uab_ab_state_t ab_state;
	uab_wake_state_t wk_state;
	logic ab_done, wake_event, wake_end;
	logic bk_busy, bk_end, hold_valid, brk_start;
	logic [3:0] bk_bit;
	logic wr, rd, wr_ctrl, wr_div, wr_tx, rd_rx, mapped;
	logic shift_empty_status, receive_idle_status;

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign wr_ctrl = wr && paddr == `UAB_ADDR_CTRL;
	assign wr_div = wr && paddr == `UAB_ADDR_DIV;
	assign wr_tx = wr && paddr == `UAB_ADDR_TXDATA;
	assign rd_rx = rd && paddr == `UAB_ADDR_RXDATA;
	assign mapped = paddr inside {`UAB_ADDR_CTRL, `UAB_ADDR_DIV, `UAB_ADDR_TXDATA, `UAB_ADDR_RXDATA};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// normal receiver idle while either measurement or wake watch runs
	assign rx_hold = autobaud_enable | wake_enable;
	assign receive_idle_status = ~rx_busy_in & ~rx_hold;
	assign shift_empty_status = ~bk_busy & ~tx_shift_busy_in;

	// receive line: three flops, a level change counts when the last two agree
	always_ff @(posedge clk)
	begin
		if (rst)
			{rx_s1, rx_s2, rx_s3, rx_lvl} <= 4'hf;
		else
		begin
			rx_s1 <= receive_line;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3)
				rx_lvl <= rx_s3;
		end
	end
	assign rx_rise = rx_s2 & rx_s3 & ~rx_lvl;
	assign rx_fall = ~rx_s2 & ~rx_s3 & rx_lvl;

	// baud base clock; the measurement clock is one eighth of it
	always_comb
	begin
		case ({wide_divisor_select, high_rate_select})
			2'b00: base_max = `UAB_BASE_DIV_SLOW;
			2'b11: base_max = `UAB_BASE_DIV_FAST;
			default: base_max = `UAB_BASE_DIV_MID;
		endcase
	end
	assign base_tick = base_cnt >= base_max;
	assign abd_tick = base_tick && abd_sub == `UAB_ABD_SUBDIV;

	always_ff @(posedge clk)
	begin
		if (rst || base_tick)
			base_cnt <= 6'd0;
		else
			base_cnt <= base_cnt + 6'd1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			abd_sub <= 3'd0;
		else if (base_tick)
			abd_sub <= abd_sub + 3'd1;
	end

	// bit timer for the break, restarted when a break begins
	assign bit_tick = base_tick && bit_cnt == 16'h0000;
	always_ff @(posedge clk)
	begin
		if (rst || brk_start || bit_tick)
			bit_cnt <= wide_divisor_select ? divisor_pair : {8'h00, divisor_pair[7:0]};
		else if (base_tick)
			bit_cnt <= bit_cnt - 16'h0001;
	end

	// measurement of the sync character
	always_ff @(posedge clk)
	begin
		if (rst || !autobaud_enable)
		begin
			ab_state <= AB_IDLE;
			ab_count <= `UAB_ABD_START_COUNT;
			ab_rises <= 3'd0;
		end
		else
		begin
			case (ab_state)
				AB_IDLE:
					ab_state <= wake_enable ? AB_BREAK : AB_START;
				AB_BREAK:
					if (!wake_enable)
						ab_state <= AB_START;
				AB_START:
					if (rx_fall)
						ab_state <= AB_RISE1;
				AB_RISE1:
					if (rx_rise)
						ab_state <= AB_COUNT;
				AB_COUNT:
				begin
					if (abd_tick)
						ab_count <= ab_count + 16'h0001;
					if (rx_rise)
						ab_rises <= ab_rises + 3'd1;
				end
				default:
					ab_state <= AB_IDLE;
			endcase
		end
	end
	assign ab_done = ab_state == AB_COUNT && rx_rise && ab_rises == `UAB_ABD_RISES - 3'd1;

	// wake watch: falling edge raises the flag, the next rise ends the break
	always_ff @(posedge clk)
	begin
		if (rst || !wake_enable || sync_mode)
			wk_state <= WK_IDLE;
		else
		begin
			case (wk_state)
				WK_IDLE:
					wk_state <= WK_HIGH;
				WK_HIGH:
					if (rx_fall)
						wk_state <= WK_LOW;
				WK_LOW:
					if (rx_rise)
						wk_state <= WK_IDLE;
				default:
					wk_state <= WK_IDLE;
			endcase
		end
	end
	assign wake_event = wk_state == WK_HIGH && rx_fall;
	assign wake_end = wk_state == WK_LOW && rx_rise;

	// break transmitter
	assign brk_start = wr_tx && send_break && transmit_enable && !bk_busy;
	assign bk_end = bk_busy && bit_tick && bk_bit == `UAB_BRK_LAST_BIT;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bk_busy <= 1'b0;
			bk_bit <= 4'd0;
		end
		else if (brk_start)
		begin
			bk_busy <= 1'b1;
			bk_bit <= 4'd0;
		end
		else if (bk_end)
			bk_busy <= 1'b0;
		else if (bk_busy && bit_tick)
			bk_bit <= bk_bit + 4'd1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			tx_line <= 1'b1;
		else if (bk_busy || brk_start)
			tx_line <= !brk_start && bk_bit >= `UAB_BRK_ZERO_BITS;
		else
			tx_line <= tx_line_normal;
	end

	// a byte written during the break waits for its end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hold_valid <= 1'b0;
			hold_data <= 8'h00;
			tx_req <= '0;
		end
		else
		begin
			tx_req.start <= 1'b0;
			if (wr_tx && bk_busy && !bk_end)
			begin
				hold_valid <= 1'b1;
				hold_data <= pwdata[7:0];
			end
			else if (wr_tx && !brk_start)
			begin
				tx_req.start <= 1'b1;
				tx_req.data <= pwdata[7:0];
			end
			else if (bk_end && hold_valid)
			begin
				hold_valid <= 1'b0;
				tx_req.start <= 1'b1;
				tx_req.data <= hold_data;
			end
		end
	end

	// control bits, with hardware clears after software writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			autobaud_enable <= 1'b0;
			wake_enable <= 1'b0;
			send_break <= 1'b0;
			transmit_enable <= 1'b0;
			wide_divisor_select <= 1'b0;
			high_rate_select <= 1'b0;
			sync_mode <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				autobaud_enable <= pwdata[`UAB_BIT_ABD_EN];
				wake_enable <= pwdata[`UAB_BIT_WAKE_EN] & ~pwdata[`UAB_BIT_SYNC];
				send_break <= pwdata[`UAB_BIT_SEND_BRK];
				transmit_enable <= pwdata[`UAB_BIT_TX_EN];
				wide_divisor_select <= pwdata[`UAB_BIT_WIDE];
				high_rate_select <= pwdata[`UAB_BIT_HIGH];
				sync_mode <= pwdata[`UAB_BIT_SYNC];
			end
			if (ab_done)
				autobaud_enable <= 1'b0;
			if (wake_end)
				wake_enable <= 1'b0;
			if (bk_end)
				send_break <= 1'b0;
		end
	end

	// overflow: set wins; a clear only acts once enable is already low
	always_ff @(posedge clk)
	begin
		if (rst)
			autobaud_overflow_flag <= 1'b0;
		else if (ab_state == AB_COUNT && abd_tick && ab_count == 16'hFFFF)
			autobaud_overflow_flag <= 1'b1;
		else if (wr_ctrl && !pwdata[`UAB_BIT_ABD_OVF] && !autobaud_enable)
			autobaud_overflow_flag <= 1'b0;
	end

	// receive flag: any set wins over the read that clears it
	always_ff @(posedge clk)
	begin
		if (rst)
			receive_flag <= 1'b0;
		else if (ab_done || wake_event || (rx_byte_in.done && !rx_hold))
			receive_flag <= 1'b1;
		else if (rd_rx)
			receive_flag <= 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			receive_data_reg <= 8'h00;
		else if (rx_byte_in.done && !rx_hold)
			receive_data_reg <= rx_byte_in.data;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			divisor_pair <= `UAB_DIV_RESET;
		else if (ab_done)
			divisor_pair <= ab_count;
		else if (wr_div && !autobaud_enable)
			divisor_pair <= pwdata[15:0];
	end

	// read data, registered at the setup phase so it is stable in the access phase
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				`UAB_ADDR_CTRL:
				begin
					prdata <= 32'h0000_0000;
					prdata[`UAB_BIT_ABD_EN] <= autobaud_enable;
					prdata[`UAB_BIT_WAKE_EN] <= wake_enable;
					prdata[`UAB_BIT_SEND_BRK] <= send_break;
					prdata[`UAB_BIT_TX_EN] <= transmit_enable;
					prdata[`UAB_BIT_WIDE] <= wide_divisor_select;
					prdata[`UAB_BIT_HIGH] <= high_rate_select;
					prdata[`UAB_BIT_SYNC] <= sync_mode;
					prdata[`UAB_BIT_ABD_OVF] <= autobaud_overflow_flag;
					prdata[`UAB_BIT_RX_IDLE] <= receive_idle_status;
					prdata[`UAB_BIT_SHIFT_EMPTY] <= shift_empty_status;
					prdata[`UAB_BIT_RX_FLAG] <= receive_flag;
				end
				`UAB_ADDR_DIV:
					prdata <= {16'h0000, divisor_pair};
				`UAB_ADDR_RXDATA:
					prdata <= {24'h00_0000, receive_data_reg};
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ==== tb/uab_core_chk.sv ====
// port-level assertions for the autobaud, wake and break core
`timescale 1ns/10ps
`include "uab_defs.svh"
module uab_core_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic receive_line,
	input wire logic tx_line_normal,
	input wire logic tx_line,
	input wire logic rx_hold,
	input wire logic [15:0] divisor_pair,
	input wire uab_pkg::uab_tx_req_t tx_req
);
	import uab_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire acc = psel && penable;
	wire bad = !(paddr inside {`UAB_ADDR_CTRL, `UAB_ADDR_DIV, `UAB_ADDR_TXDATA, `UAB_ADDR_RXDATA});
	wire wr_ctl = acc && pwrite && paddr == `UAB_ADDR_CTRL;
	wire wr_div = acc && pwrite && paddr == `UAB_ADDR_DIV;
	wire wr_tx = acc && pwrite && paddr == `UAB_ADDR_TXDATA;
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	property p_err; acc |-> pslverr == bad; endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_rd0; acc && !pwrite && bad |-> prdata == 32'h0000_0000; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_div; $changed(divisor_pair) |-> $past(wr_div) || $fell(rx_hold); endproperty
	a_div: assert property (p_div) else $error("divisor changed without cause");
	property p_rise; $rose(rx_hold) |-> $past(wr_ctl); endproperty
	a_rise: assert property (p_rise) else $error("hold rose without write");
	property p_fall; $fell(rx_hold) && !$past(wr_ctl) |-> $past(receive_line, 3); endproperty
	a_fall: assert property (p_fall) else $error("hold fell without rising line");
	property p_txl; tx_line != $past(tx_line_normal) |-> !tx_line; endproperty
	a_txl: assert property (p_txl) else $error("tx line not normal or low");
	property p_req; tx_req.start |-> $past(wr_tx) || tx_line; endproperty
	a_req: assert property (p_req) else $error("tx request without cause");
	property p_pulse; tx_req.start |=> !tx_req.start; endproperty
	a_pulse: assert property (p_pulse) else $error("tx request too long");
endmodule
bind uab_core uab_core_chk chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .receive_line(receive_line),
	.tx_line_normal(tx_line_normal), .tx_line(tx_line), .rx_hold(rx_hold), .divisor_pair(divisor_pair),
	.tx_req(tx_req));

// ==== tb/uab_node.sv ====
// remote serial node driving the receive line
`timescale 1ns/10ps
module uab_node
(
	input wire logic clk,
	output logic line
);
	initial line = 1'b1;
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask
	task automatic send_byte(input logic [7:0] b, input int p);
		hold(1'b0, p);
		for (int i = 0; i < 8; i++)
			hold(b[i], p);
		hold(1'b1, p);
	endtask
	task automatic send_break(input int nbits, input int p);
		hold(1'b0, nbits * p);
		hold(1'b1, p);
	endtask
endmodule

// ==== tb/uab_core_bench.sv ====
// self-checking bench for the autobaud, wake and break core
`timescale 1ns/10ps
`include "uab_defs.svh"
module uab_core_bench;
	import uab_pkg::*;
	logic clk, rst, psel, penable, pwrite, rx_busy_in, tx_shift_busy_in, tx_line_normal, err;
	logic receive_line, pready, pslverr, tx_line, rx_hold;
	logic [7:0] paddr, req_data = 8'h00;
	logic [31:0] pwdata, prdata, rd, w, h, r;
	logic [15:0] divisor_pair, e;
	uab_rx_byte_t rx_byte_in;
	uab_tx_req_t tx_req;
	int n_mismatch = 0, comparisons = 0, low_n = 0, last_low = 0, p;
	uab_node node (.clk(clk), .line(receive_line));
	uab_core uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .receive_line(receive_line),
		.rx_byte_in(rx_byte_in), .rx_busy_in(rx_busy_in), .tx_shift_busy_in(tx_shift_busy_in),
		.tx_line_normal(tx_line_normal), .tx_line(tx_line), .rx_hold(rx_hold), .divisor_pair(divisor_pair),
		.tx_req(tx_req));
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
		comparisons++;
		if (g !== ex)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, ex, g);
		end
	endtask
	task automatic chk_rng(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
		comparisons++;
		if ((^g === 1'bx) || (g < lo) || (g > hi))
		begin
			n_mismatch++;
			$display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] abd_exp(input int q, input logic ws, input logic hs);
		return 16'(1 + 8 * q / (ws && hs ? 32 : ws || hs ? 128 : 512));
	endfunction
	// low run length of the serial output and the last byte requested
	always @(posedge clk)
	begin
		low_n <= (tx_line === 1'b0) ? low_n + 1 : 0;
		if (tx_line === 1'b1 && low_n != 0)
			last_low <= low_n;
		if (tx_req.start === 1'b1)
			req_data <= tx_req.data;
	end
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#(90000 * 50);
		n_mismatch++;
		end_sim;
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_byte_in, rx_busy_in, tx_shift_busy_in} = '0;
		tx_line_normal = 1'b1;
		rst = 1'b1;
		void'($urandom(32'hd0a2_7c35));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("ctrl reset", 0, rd & 32'h0000_00ff);
		apb(0, 8'h10, 0);
		chk("unmapped", 1, err);
		for (int k = 0; k < 5; k++)
		begin
			w = k % 2;
			h = (k / 2 % 2) | (k == 4);
			p = (k == 4) ? 4200 : 160 + $urandom_range(160);
			e = abd_exp(p, w[0], h[0]);
			apb(1, `UAB_ADDR_DIV, $urandom & 32'h0000_ffff);
			apb(1, `UAB_ADDR_CTRL, 32'h0000_0001 | w << `UAB_BIT_WIDE | h << `UAB_BIT_HIGH);
			chk("hold", 1, rx_hold);
			node.send_byte(8'h55, p);
			repeat (8) @(posedge clk);
			chk_rng("count", e - 1, e + 1, divisor_pair);
			apb(0, `UAB_ADDR_CTRL, 0);
			chk("abd done", 32'h0000_0400, rd & 32'h0000_0401);
			apb(0, `UAB_ADDR_RXDATA, 0);
			apb(0, `UAB_ADDR_CTRL, 0);
			chk("flag clear", 0, rd & 32'h0000_0400);
		end
		chk("rx idle", 32'h0000_0100, rd & 32'h0000_0100);
		apb(1, `UAB_ADDR_CTRL, 32'h0000_0003);
		fork
			node.send_break(13, 256);
			begin
				repeat (600) @(posedge clk);
				apb(0, `UAB_ADDR_CTRL, 0);
				chk("wake flag", 32'h0000_0403, rd & 32'h0000_0403);
			end
		join
		repeat (8) @(posedge clk);
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("wake end", 32'h0000_0401, rd & 32'h0000_0403);
		apb(0, `UAB_ADDR_RXDATA, 0);
		node.send_byte(8'h55, 256);
		repeat (8) @(posedge clk);
		chk_rng("count after break", 4, 6, divisor_pair);
		apb(1, `UAB_ADDR_DIV, 3);
		apb(1, `UAB_ADDR_CTRL, 32'h0000_002c);
		apb(1, `UAB_ADDR_TXDATA, $urandom);
		apb(1, `UAB_ADDR_TXDATA, 32'h0000_0055);
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("break busy", 32'h0000_0004, rd & 32'h0000_0204);
		repeat (1000) @(posedge clk);
		chk_rng("break low", 815, 833, 32'(last_low));
		chk("sync byte", 32'h0000_0055, req_data);
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("break end", 32'h0000_0208, rd & 32'h0000_020c);
		r = $urandom & 32'h0000_00ff;
		apb(1, `UAB_ADDR_CTRL, 32'h0000_0008);
		apb(1, `UAB_ADDR_TXDATA, r);
		repeat (2) @(posedge clk);
		chk("tx byte", r, req_data);
		tx_line_normal <= 1'b0;
		repeat (3) @(posedge clk);
		chk("tx pass", 0, tx_line);
		tx_line_normal <= 1'b1;
		apb(1, `UAB_ADDR_CTRL, 32'h0000_0001);
		apb(1, `UAB_ADDR_CTRL, 0);
		chk("abort", 0, rx_hold);
		apb(0, `UAB_ADDR_RXDATA, 0);
		apb(1, `UAB_ADDR_CTRL, 32'h0000_0002);
		node.send_byte(8'h38, 64);
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("wake by char", 32'h0000_0400, rd & 32'h0000_0402);
		apb(0, `UAB_ADDR_RXDATA, 0);
		rx_busy_in <= 1'b1;
		tx_shift_busy_in <= 1'b1;
		r = $urandom & 32'h0000_00ff;
		rx_byte_in <= {1'b1, r[7:0]};
		@(posedge clk);
		rx_byte_in <= '0;
		apb(0, `UAB_ADDR_CTRL, 0);
		chk("busy status", 32'h0000_0400, rd & 32'h0000_0700);
		apb(0, `UAB_ADDR_RXDATA, 0);
		chk("rx byte", r, rd);
		rx_busy_in <= 1'b0;
		tx_shift_busy_in <= 1'b0;
		end_sim;
	end
endmodule
